//--- slf_pkg.sv
// constants and helpers for the store-to-load forwarding check
// assumes one core clock, synchronous reset, in-order store allocation
//
// Contract
// - load spanning several smaller stores is held
// - load held on a partial overlap reads cache after stores drain
// - narrow load at offset into store stalls
// - word at an offset inside quadword waits for store drain
// - partly newer byte, partly older store stalls
// - missing store data delays the dependent load
// - predict store-dependent loads, schedule by prediction
// - forward only with identical start address
// - forward only if store holds every byte
// - stores reach cache only after retirement
// - unrelated loads proceed without waiting
`default_nettype none

package slf_pkg;

  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 64;
  localparam int SQ_DEPTH     = 8;
  localparam int SQ_PTR_W     = 3;
  localparam int SQ_CNT_W     = 4;
  localparam int SIZE_W       = 2;
  localparam int PRED_ENTRIES = 16;
  localparam int PRED_IDX_W   = 4;
  localparam int PRED_IDX_LSB = 3;

  localparam logic [SQ_CNT_W-1:0] SQ_FULL = 4'h8;

  // access size, log2 of the byte count
  typedef enum logic [SIZE_W-1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_DWORD,
    SZ_QWORD
  } slf_size_type;

  function automatic logic [ADDR_W:0] slf_bytes(
    input logic [SIZE_W-1:0] size
  );
    slf_bytes = (ADDR_W+1)'(1) << size;
  endfunction

  // true when two byte ranges share at least one byte
  function automatic logic slf_overlap(
    input logic [ADDR_W-1:0] a_addr,
    input logic [SIZE_W-1:0] a_size,
    input logic [ADDR_W-1:0] b_addr,
    input logic [SIZE_W-1:0] b_size
  );
    logic [ADDR_W:0] a_end;
    logic [ADDR_W:0] b_end;
    a_end = {1'b0, a_addr} + slf_bytes(a_size);
    b_end = {1'b0, b_addr} + slf_bytes(b_size);
    slf_overlap = ({1'b0, a_addr} < b_end) && ({1'b0, b_addr} < a_end);
  endfunction

  function automatic logic [DATA_W-1:0] slf_lane_mask(
    input logic [SIZE_W-1:0] size
  );
    slf_lane_mask = {DATA_W{1'b1}} >> (DATA_W - 8 * (1 << size));
  endfunction

endpackage

`default_nettype wire

//--- slf_forward_check.sv
// store buffer with store-to-load forwarding check
// assumes the pipeline allocates stores in program order, presents
// at most one load per cycle that is younger than every store already
// allocated, and the cache accepts drained stores with a ready
`default_nettype none

module slf_forward_check
  import slf_pkg::*;
(
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // store allocation
  input  wire logic                          st_alloc_valid,
  output logic                               st_alloc_ready,
  input  wire logic [slf_pkg::ADDR_W-1:0]    st_alloc_addr,
  input  wire logic [slf_pkg::SIZE_W-1:0]    st_alloc_size,
  output logic      [slf_pkg::SQ_PTR_W-1:0]  st_alloc_idx,
  // store data arrival
  input  wire logic                          st_data_valid,
  input  wire logic [slf_pkg::SQ_PTR_W-1:0]  st_data_idx,
  input  wire logic [slf_pkg::DATA_W-1:0]    st_data,
  // store retirement, oldest first
  input  wire logic                          st_retire,
  // load request and result
  input  wire logic                          ld_req_valid,
  output logic                               ld_req_ready,
  input  wire logic [slf_pkg::ADDR_W-1:0]    ld_req_addr,
  input  wire logic [slf_pkg::SIZE_W-1:0]    ld_req_size,
  output logic                               ld_pred_dep,
  output logic                               ld_done,
  output logic                               ld_from_cache,
  output logic      [slf_pkg::DATA_W-1:0]    ld_data,
  output logic                               ld_wait,
  output logic                               ld_blocked,
  // drain to data cache
  output logic                               cache_wr_valid,
  input  wire logic                          cache_wr_ready,
  output logic      [slf_pkg::ADDR_W-1:0]    cache_wr_addr,
  output logic      [slf_pkg::SIZE_W-1:0]    cache_wr_size,
  output logic      [slf_pkg::DATA_W-1:0]    cache_wr_data
);
  import slf_pkg::*;

  // store queue, entries kept in age order from head
  logic [ADDR_W-1:0]   addr_r  [SQ_DEPTH];
  logic [ADDR_W-1:0]   addr_nxt[SQ_DEPTH];
  logic [SIZE_W-1:0]   size_r  [SQ_DEPTH];
  logic [SIZE_W-1:0]   size_nxt[SQ_DEPTH];
  logic [DATA_W-1:0]   data_r  [SQ_DEPTH];
  logic [DATA_W-1:0]   data_nxt[SQ_DEPTH];
  logic [SQ_DEPTH-1:0] dv_r;
  logic [SQ_DEPTH-1:0] dv_nxt;
  logic [SQ_PTR_W-1:0] head_r;
  logic [SQ_PTR_W-1:0] head_nxt;
  logic [SQ_PTR_W-1:0] tail_r;
  logic [SQ_PTR_W-1:0] tail_nxt;
  logic [SQ_CNT_W-1:0] count_r;
  logic [SQ_CNT_W-1:0] count_nxt;
  logic [SQ_CNT_W-1:0] rcnt_r;
  logic [SQ_CNT_W-1:0] rcnt_nxt;

  // dependence predictor, one bit per address slot
  logic [PRED_ENTRIES-1:0] pred_r;
  logic [PRED_ENTRIES-1:0] pred_nxt;

  // load result flops
  logic              done_r;
  logic              done_nxt;
  logic              from_cache_r;
  logic              from_cache_nxt;
  logic [DATA_W-1:0] ldata_r;
  logic [DATA_W-1:0] ldata_nxt;
  logic              wait_r;
  logic              wait_nxt;
  logic              blocked_r;
  logic              blocked_nxt;

  // check terms
  logic                  hit;
  logic [SQ_PTR_W-1:0]   yng;
  logic [SQ_PTR_W-1:0]   idx;
  logic                  contain;
  logic                  fwd_ok;
  logic                  hold;
  logic                  take;
  logic                  alloc;
  logic                  ret;
  logic                  pop;
  logic [PRED_IDX_W-1:0] pidx;

  // queue pointer step; the depth is a power of two, so the sum wraps
  function automatic logic [SQ_PTR_W-1:0] ptr_add(
    input logic [SQ_PTR_W-1:0] ptr,
    input int                  step
  );
    ptr_add = ptr + SQ_PTR_W'(step);
  endfunction

  assign st_alloc_ready = (count_r != SQ_FULL);
  assign st_alloc_idx   = tail_r;
  // ready falls in the very cycle the check refuses, so a taken load
  // never has to be replayed by the pipeline
  assign ld_req_ready   = !hold;
  assign ld_done        = done_r;
  assign ld_from_cache  = from_cache_r;
  assign ld_data        = ldata_r;
  assign ld_wait        = wait_r;
  assign ld_blocked     = blocked_r;
  // a retired store leaves for the cache only once its data is in
  assign cache_wr_valid = (rcnt_r != '0) && dv_r[head_r];
  assign cache_wr_addr  = addr_r[head_r];
  assign cache_wr_size  = size_r[head_r];
  assign cache_wr_data  = data_r[head_r];
  assign pidx           = ld_req_addr[PRED_IDX_LSB +: PRED_IDX_W];
  // the prediction only steers scheduling; holds use the real check
  assign ld_pred_dep    = pred_r[pidx];

  always_comb begin
    addr_nxt       = addr_r;
    size_nxt       = size_r;
    data_nxt       = data_r;
    dv_nxt         = dv_r;
    pred_nxt       = pred_r;
    hit            = 1'b0;
    yng            = head_r;
    idx            = head_r;

    // walk oldest to youngest so the last overlap found is the youngest
    for (int k = 0; k < SQ_DEPTH; k++) begin
      idx = ptr_add(head_r, k);
      if (SQ_CNT_W'(k) < count_r &&
          slf_overlap(addr_r[idx], size_r[idx], ld_req_addr,
                      ld_req_size)) begin
        hit = 1'b1;
        yng = idx;
      end
    end

    // same start and whole load inside one store, else refuse
    contain = hit && (addr_r[yng] == ld_req_addr) &&
              (ld_req_size <= size_r[yng]);
    // a partial youngest store is never merged with older bytes
    fwd_ok  = contain && dv_r[yng];
    // refused loads stay held until the overlap drains, data waits
    // until the store data arrives; overlap-free loads never wait
    hold    = ld_req_valid && hit && !fwd_ok;
    take    = ld_req_valid && !hold;

    done_nxt       = take;
    from_cache_nxt = take && !hit;
    ldata_nxt      = ldata_r;
    if (take && hit) begin
      ldata_nxt = data_r[yng] & slf_lane_mask(ld_req_size);
    end
    wait_nxt    = hold;
    blocked_nxt = hold && !contain;

    // train: any overlap marks the slot dependent, a clean load clears
    if (ld_req_valid) begin
      pred_nxt[pidx] = hit;
    end

    // a store allocated this cycle is seen by the check only from the next
    alloc = st_alloc_valid && st_alloc_ready;
    ret   = st_retire && (rcnt_r < count_r);
    pop   = cache_wr_valid && cache_wr_ready;

    if (alloc) begin
      addr_nxt[tail_r] = st_alloc_addr;
      size_nxt[tail_r] = st_alloc_size;
      dv_nxt[tail_r]   = 1'b0;
    end
    if (st_data_valid) begin
      data_nxt[st_data_idx] = st_data;
      dv_nxt[st_data_idx]   = 1'b1;
    end

    head_nxt  = pop ? ptr_add(head_r, 1) : head_r;
    tail_nxt  = alloc ? ptr_add(tail_r, 1) : tail_r;
    count_nxt = count_r + SQ_CNT_W'(alloc) - SQ_CNT_W'(pop);
    rcnt_nxt  = rcnt_r + SQ_CNT_W'(ret) - SQ_CNT_W'(pop);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dv_r         <= '0;
      head_r       <= '0;
      tail_r       <= '0;
      count_r      <= '0;
      rcnt_r       <= '0;
      pred_r       <= '0;
      done_r       <= 1'b0;
      from_cache_r <= 1'b0;
      ldata_r      <= '0;
      wait_r       <= 1'b0;
      blocked_r    <= 1'b0;
      for (int k = 0; k < SQ_DEPTH; k++) begin
        addr_r[k] <= '0;
        size_r[k] <= '0;
        data_r[k] <= '0;
      end
    end else begin
      addr_r       <= addr_nxt;
      size_r       <= size_nxt;
      data_r       <= data_nxt;
      dv_r         <= dv_nxt;
      head_r       <= head_nxt;
      tail_r       <= tail_nxt;
      count_r      <= count_nxt;
      rcnt_r       <= rcnt_nxt;
      pred_r       <= pred_nxt;
      done_r       <= done_nxt;
      from_cache_r <= from_cache_nxt;
      ldata_r      <= ldata_nxt;
      wait_r       <= wait_nxt;
      blocked_r    <= blocked_nxt;
    end
  end

endmodule

`default_nettype wire

//--- slf_forward_check_end.sv
// intentionally empty companion: no further logic
`default_nettype none
`default_nettype wire

//--- slf_forward_check_asserts.sv
// port assertions for the forwarding check
// bound to slf_forward_check in the bench top
`default_nettype none
module slf_forward_check_asserts
  import slf_pkg::*;
(
  // clock and reset
  input wire logic                        clock,
  input wire logic                        reset,
  // store side
  input wire logic                        st_retire,
  input wire logic                        st_data_valid,
  // load side
  input wire logic                        ld_req_valid,
  input wire logic                        ld_req_ready,
  input wire logic [slf_pkg::SIZE_W-1:0]  ld_req_size,
  input wire logic                        ld_done,
  input wire logic                        ld_from_cache,
  input wire logic [slf_pkg::DATA_W-1:0]  ld_data,
  input wire logic                        ld_wait,
  input wire logic                        ld_blocked,
  // drain
  input wire logic                        cache_wr_valid,
  input wire logic                        cache_wr_ready,
  input wire logic [slf_pkg::ADDR_W-1:0]  cache_wr_addr,
  input wire logic [slf_pkg::DATA_W-1:0]  cache_wr_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_take;
    ld_req_valid && ld_req_ready;
  endsequence
  sequence s_hold;
    ld_req_valid && !ld_req_ready;
  endsequence
  a_done_after_take: assert property (s_take |=> ld_done)
    else $error("done missing");
  a_no_stray_done: assert property (
    !(ld_req_valid && ld_req_ready) |=> !ld_done) else $error("stray done");
  a_wait_after_hold: assert property (s_hold |=> ld_wait)
    else $error("wait missing");
  a_take_no_wait: assert property (s_take |=> !ld_wait)
    else $error("wait after take");
  a_blocked_is_held: assert property (
    ld_blocked |-> ld_wait && $past(ld_req_valid)) else $error("bad block");
  a_drain_stable: assert property (
    cache_wr_valid && !cache_wr_ready |=> cache_wr_valid
    && $stable(cache_wr_addr) && $stable(cache_wr_data))
    else $error("drain moved");
  a_fwd_masked: assert property (
    ld_done && !ld_from_cache |->
    (ld_data & ~slf_lane_mask($past(ld_req_size))) == '0)
    else $error("fwd unmasked");
  a_drain_cause: assert property ($rose(cache_wr_valid) |->
    $past(st_retire || st_data_valid))
    else $error("drain uncaused");
endmodule
`default_nettype wire

//--- slf_cache_model.sv
// data cache stand-in taking drained stores
// ready answers a pending write, one cycle in four at random while slow
`default_nettype none
module slf_cache_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // pacing
  input  wire logic slow,
  // write port
  input  wire logic cache_wr_valid,
  output var logic  cache_wr_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clock)
    cache_wr_ready <= !reset && cache_wr_valid &&
                      (!slow || $urandom_range(3) == 0);
endmodule
`default_nettype wire

//--- slf_forward_check_bench.sv
// bench for the store-to-load forwarding check
// drives at the falling edge; the cache model paces the drain
`default_nettype none
module slf_forward_check_bench import slf_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, reset = 1, slow = 1, pn = 0, st_alloc_valid = 0;
  logic st_data_valid = 0, st_retire = 0, ld_req_valid = 0;
  logic [ADDR_W-1:0] st_alloc_addr = 0, ld_req_addr = 0, a;
  logic [SIZE_W-1:0] st_alloc_size = 0, ld_req_size = 0;
  logic [SQ_PTR_W-1:0] st_alloc_idx, st_data_idx = 0;
  logic [DATA_W-1:0] st_data = 0, ld_data, d = 0;
  logic st_alloc_ready, ld_req_ready, ld_pred_dep, ld_done, ld_from_cache;
  logic ld_wait, ld_blocked, cache_wr_valid, cache_wr_ready;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  logic [DATA_W:0] q[$];
  logic [ADDR_W-1:0] wr_addr;
  logic [SIZE_W-1:0] wr_size;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W+SIZE_W+DATA_W-1:0] dq[$];
  slf_forward_check dut (.clock, .reset, .st_alloc_valid, .st_alloc_ready,
    .st_alloc_addr, .st_alloc_size, .st_alloc_idx, .st_data_valid,
    .st_data_idx, .st_data, .st_retire, .ld_req_valid, .ld_req_ready,
    .ld_req_addr, .ld_req_size, .ld_pred_dep, .ld_done, .ld_from_cache,
    .ld_data, .ld_wait, .ld_blocked, .cache_wr_valid, .cache_wr_ready,
    .cache_wr_addr(wr_addr), .cache_wr_size(wr_size),
    .cache_wr_data(wr_data));
  slf_cache_model mem (.clock, .reset, .slow, .cache_wr_valid,
    .cache_wr_ready);
  initial forever #2.5 clock = ~clock;
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [DATA_W-1:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [DATA_W-1:0] msk(logic [SIZE_W-1:0] s);
    return s == 3 ? '1 : (DATA_W'(1) << (8 << s)) - 1;
  endfunction
  // the load result expected is noted before the load is presented
  task automatic st(logic [ADDR_W-1:0] sa, logic [SIZE_W-1:0] ss, logic w);
    ld_req_valid = 0;
    d = {$urandom, $urandom};
    dq.push_back({sa, ss, d});
    st_alloc_valid = 1;
    st_alloc_addr = sa;
    st_alloc_size = ss;
    st_data_idx = st_alloc_idx;
    st_data = d;
    @(negedge clock);
    st_alloc_valid = 0;
    st_data_valid = w;
    @(negedge clock);
    st_data_valid = 0;
  endtask
  // valid stays up on return so back-to-back loads need no idle cycle
  task automatic ld(logic [ADDR_W-1:0] la, logic [SIZE_W-1:0] ls,
                    logic fc, hx, rt, logic [1:0] p);
    int h;
    h = 0;
    q.push_back({fc, d & msk(ls)});
    ld_req_valid = 1;
    ld_req_addr = la;
    ld_req_size = ls;
    #1;
    if (p[1]) chk("pred", p[0], ld_pred_dep);
    while (!ld_req_ready && h < 300) begin
      h++;
      @(negedge clock);
      st_retire = rt;
      st_data_valid = pn && h == 3;
      #1;
      if (h == 1) chk("wait", 1, ld_wait);
      if (h == 1) chk("blocked", fc, ld_blocked);
    end
    chk("limit", 0, h >= 300);
    @(negedge clock);
    st_retire = 0;
    st_data_valid = 0;
    chk("held", hx, h != 0);
  endtask
  task automatic fl();
    ld_req_valid = 0;
    st_retire = 1;
    repeat (8) @(negedge clock);
    st_retire = 0;
    for (int i = 0; i < 200 && cache_wr_valid; i++) @(negedge clock);
    chk("drained", 0, cache_wr_valid);
  endtask
  always @(negedge clock) begin
    if (!reset && ld_done === 1'b1 && q.size() > 0) begin
      chk("src", q[0][DATA_W], ld_from_cache);
      if (!q[0][DATA_W]) chk("data", q[0][DATA_W-1:0], ld_data);
      void'(q.pop_front());
    end else if (!reset && ld_done === 1'b1) begin
      chk("extra_done", 0, 1);
    end
    if (!reset && cache_wr_valid === 1'b1 && cache_wr_ready === 1'b1) begin
      if (dq.size() == 0) begin
        chk("extra_wr", 0, 1);
      end else begin
        chk("wr_addr", dq[0][DATA_W+SIZE_W+:ADDR_W], wr_addr);
        chk("wr_size", dq[0][DATA_W+:SIZE_W], wr_size);
        chk("wr_data", dq[0][DATA_W-1:0], wr_data);
        void'(dq.pop_front());
      end
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h2D875D7A));
    a = $urandom & 32'hFFFF_FF80;
    repeat (3) @(negedge clock);
    reset = 0;
    chk("idx", 0, st_alloc_idx);
    st(a, 3, 1);
    ld(a, 1, 0, 0, 0, 0);
    ld(a + 2, 1, 1, 1, 1, 0);
    fl();
    for (int i = 0; i < 4; i++) st(a + i, 0, 1);
    ld(a, 2, 1, 1, 1, 0);
    fl();
    slow = 0;
    st(a, 2, 1);
    ld(a, 2, 0, 0, 0, 0);
    fl();
    slow = 1;
    st(a + 32'h10, 2, 1);
    st(a + 32'h10, 0, 1);
    ld(a + 32'h10, 2, 1, 1, 1, 0);
    st(a + 32'h10, 0, 1);
    st(a + 32'h10, 2, 1);
    ld(a + 32'h10, 0, 0, 0, 0, 0);
    fl();
    st(a + 32'h40, 3, 0);
    pn = 1;
    ld(a + 32'h108, 3, 1, 0, 0, 2'b10);
    ld(a + 32'h40, 3, 0, 1, 0, 0);
    pn = 0;
    ld(a + 32'h40, 0, 0, 0, 0, 2'b11);
    chk("drain", 0, cache_wr_valid);
    fl();
    chk("left", 0, q.size());
    chk("left_wr", 0, dq.size());
    print_verdict();
  end
endmodule
bind slf_forward_check slf_forward_check_asserts chk_u (.clock, .reset,
  .st_retire, .st_data_valid, .ld_req_valid, .ld_req_ready, .ld_req_size,
  .ld_done, .ld_from_cache, .ld_data, .ld_wait, .ld_blocked,
  .cache_wr_valid, .cache_wr_ready, .cache_wr_addr, .cache_wr_data);
`default_nettype wire
